/* File: wdd_watchdog.sv */
// Watchdog time base: divider, prescaled time-outs, early warning and registers
`include "wdd_params.svh"
`default_nettype none
module wdd_watchdog
  import wdd_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Register port
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrStb,
  input  wire logic       regRdStb,
  output var  logic [7:0] regRdData,
  // Watchdog side
  input  wire logic       slowOscillatorClock,
  input  wire logic       wdRestart,
  input  wire logic       vectorAck,
  // Events and interrupts
  output var  logic       earlyWarnIrq,
  output var  logic       secondTimeout,
  output var  logic       irq
);

  logic              oscS1_r, oscS2_r, oscS3_r;
  logic              slowTick;
  logic              countTick;
  logic              clrMode_r, ewEnable_r, ewFlag_r;
  wdd_div_sel_type   divSel_r;
  wdd_presc_sel_type presc_r;
  logic [1:0]        sts_r, mask_r;
  wdd_phase_type     phase_r;
  wdd_count_type     cnt_r;
  wdd_count_type     limit;
  logic              hit, firstEvt, secondEvt;
  logic              wrCtrl, wrSts, wrMask, wrPresc;
  logic              ewFlag_nxt;
  logic [1:0]        sts_nxt;

  // Reset image of the control register, sliced per field
  localparam logic [7:0] RstCtrl = `WDD_RST_DIV_CTRL;

  // Reserved codes fold onto the longest period
  function automatic wdd_count_type prescLimit(input wdd_presc_sel_type code);
    wdd_presc_sel_type c;
    c = (code > `WDD_MAX_PRESCALE) ? `WDD_MAX_PRESCALE : code;
    prescLimit = `WDD_BASE_COUNT << c;
  endfunction

  function automatic logic wrHit(input logic [7:0] ofs);
    wrHit = regWrStb && (regAddr == ofs);
  endfunction

  assign wrCtrl  = wrHit(`WDD_OFS_DIV_CTRL);
  assign wrPresc = wrHit(`WDD_OFS_PRESCALE);
  assign wrSts   = wrHit(`WDD_OFS_IRQ_STATUS);
  assign wrMask  = wrHit(`WDD_OFS_IRQ_MASK);

  // Pin passes two flops before edge detect
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      oscS1_r <= 1'b0;
      oscS2_r <= 1'b0;
      oscS3_r <= 1'b0;
    end
    else
    begin
      oscS1_r <= slowOscillatorClock;
      oscS2_r <= oscS1_r;
      oscS3_r <= oscS2_r;
    end
  end

  assign slowTick = oscS2_r && !oscS3_r;

  wdd_tick_divider uDiv (
    .core_clk  (core_clk),
    .rst       (rst),
    .slowTick  (slowTick),
    .divSel    (divSel_r),
    .countTick (countTick)
  );

  // Time-out counting, one interval per phase
  assign limit     = prescLimit(presc_r);
  assign hit       = countTick && (cnt_r + 21'h1 >= limit);
  assign firstEvt  = hit && (phase_r == PH_FIRST);
  assign secondEvt = hit && (phase_r == PH_SECOND);

  always_ff @(posedge core_clk)
  begin
    if (rst || wdRestart)
    begin
      cnt_r   <= 21'h0;
      phase_r <= PH_FIRST;
    end
    else if (hit)
    begin
      cnt_r <= 21'h0;
      case (phase_r)
        PH_FIRST:  phase_r <= PH_SECOND;
        PH_SECOND: phase_r <= PH_FIRST;
        default:   phase_r <= PH_FIRST;
      endcase
    end
    else if (countTick)
      cnt_r <= cnt_r + 21'h1;
  end

  // Control fields
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      clrMode_r  <= RstCtrl[`WDD_BIT_CLR_MODE];
      ewEnable_r <= RstCtrl[`WDD_BIT_EW_ENABLE];
      divSel_r   <= {RstCtrl[`WDD_BIT_SEL_MSB], RstCtrl[`WDD_BIT_SEL_MID],
                     RstCtrl[`WDD_BIT_SEL_LSB]};
      presc_r    <= `WDD_RST_PRESCALE;
      mask_r     <= `WDD_RST_STS;
    end
    else
    begin
      if (wrCtrl)
      begin
        clrMode_r  <= regWrData[`WDD_BIT_CLR_MODE];
        ewEnable_r <= regWrData[`WDD_BIT_EW_ENABLE];
        divSel_r   <= {regWrData[`WDD_BIT_SEL_MSB],
                       regWrData[`WDD_BIT_SEL_MID], regWrData[`WDD_BIT_SEL_LSB]};
      end
      if (wrPresc)
        presc_r <= regWrData[3:0];
      if (wrMask)
        mask_r <= regWrData[1:0];
    end
  end

  // Flag: set wins over any clear
  always_comb
  begin
    ewFlag_nxt = ewFlag_r;
    if (wrCtrl && regWrData[`WDD_BIT_EW_FLAG])
      ewFlag_nxt = 1'b0;
    if (vectorAck && !clrMode_r)
      ewFlag_nxt = 1'b0;
    if (firstEvt && ewEnable_r)
      ewFlag_nxt = 1'b1;
  end

  always_comb
  begin
    sts_nxt = sts_r;
    if (wrSts)
      sts_nxt = sts_r & ~regWrData[1:0];
    sts_nxt[`WDD_BIT_STS_EARLY]  = sts_nxt[`WDD_BIT_STS_EARLY] | firstEvt;
    sts_nxt[`WDD_BIT_STS_SECOND] = sts_nxt[`WDD_BIT_STS_SECOND] | secondEvt;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ewFlag_r <= RstCtrl[`WDD_BIT_EW_FLAG];
      sts_r    <= `WDD_RST_STS;
    end
    else
    begin
      ewFlag_r <= ewFlag_nxt;
      sts_r    <= sts_nxt;
    end
  end

  // Outputs, all registered
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      earlyWarnIrq  <= 1'b0;
      secondTimeout <= 1'b0;
      irq           <= 1'b0;
    end
    else
    begin
      earlyWarnIrq  <= ewFlag_nxt && ewEnable_r;
      secondTimeout <= secondEvt;
      // New mask counts at once, so irq never lags a mask write
      irq           <= |(sts_nxt & (wrMask ? regWrData[1:0] : mask_r));
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk)
  begin
    if (rst || !regRdStb)
      regRdData <= 8'h00;
    else
      case (regAddr)
        `WDD_OFS_DIV_CTRL:   regRdData <= {2'h0, clrMode_r, divSel_r[2], ewFlag_r,
                                           ewEnable_r, divSel_r[1:0]};
        `WDD_OFS_PRESCALE:   regRdData <= {4'h0, presc_r};
        `WDD_OFS_IRQ_STATUS: regRdData <= {6'h00, sts_r};
        `WDD_OFS_IRQ_MASK:   regRdData <= {6'h00, mask_r};
        default:             regRdData <= 8'h00;
      endcase
  end

  sequence ctrlWrite;
    wrCtrl;
  endsequence

  sequence firstHit;
    firstEvt && ewEnable_r;
  endsequence

  ewRequest_a: assert property (@(posedge core_clk) disable iff (rst)
    firstHit |=> ewFlag_r ##0 earlyWarnIrq)
    else $error("early warning not requested");

  firstLimit_a: assert property (@(posedge core_clk) disable iff (rst)
    (countTick && !wdRestart && phase_r == PH_FIRST && cnt_r + 21'h1 < limit) |=>
    (phase_r == PH_FIRST && cnt_r == $past(cnt_r) + 21'h1))
    else $error("first time-out before limit");

  secondAfter_a: assert property (@(posedge core_clk) disable iff (rst)
    secondTimeout |-> $past(phase_r) == PH_SECOND)
    else $error("second time-out without first");

  flagSet_a: assert property (@(posedge core_clk) disable iff (rst)
    firstHit |=> ewFlag_r)
    else $error("early warning flag not set");

  flagVecClr_a: assert property (@(posedge core_clk) disable iff (rst)
    (vectorAck && !clrMode_r && !firstEvt) |=> !ewFlag_r)
    else $error("vector did not clear flag");

  clrModeKeep_a: assert property (@(posedge core_clk) disable iff (rst)
    (ewFlag_r && clrMode_r && vectorAck && !wrCtrl) |=> ewFlag_r)
    else $error("clear mode flag lost on vector");

  divMsbField_a: assert property (@(posedge core_clk) disable iff (rst)
    ctrlWrite |=> divSel_r[2] == $past(regWrData[4]))
    else $error("divider msb not from bit four");

  reservedFold_a: assert property (@(posedge core_clk) disable iff (rst)
    (presc_r > `WDD_MAX_PRESCALE) |-> limit == (`WDD_BASE_COUNT << `WDD_MAX_PRESCALE))
    else $error("reserved prescale not folded");

endmodule // wdd_watchdog
`default_nettype wire

/* File: wdd_params.svh */
// Offsets, bit positions, reset values and counts of the watchdog time base
`ifndef WDD_PARAMS_SVH
`define WDD_PARAMS_SVH

`define WDD_OFS_DIV_CTRL   8'h00
`define WDD_OFS_PRESCALE   8'h01
`define WDD_OFS_IRQ_STATUS 8'h02
`define WDD_OFS_IRQ_MASK   8'h03

`define WDD_BIT_SEL_LSB    0
`define WDD_BIT_SEL_MID    1
`define WDD_BIT_EW_ENABLE  2
`define WDD_BIT_EW_FLAG    3
`define WDD_BIT_SEL_MSB    4
`define WDD_BIT_CLR_MODE   5

`define WDD_BIT_STS_EARLY  0
`define WDD_BIT_STS_SECOND 1

`define WDD_RST_DIV_CTRL   8'h00
`define WDD_RST_PRESCALE   4'h0
`define WDD_RST_STS        2'h0

`define WDD_BASE_COUNT     21'h000800
`define WDD_MAX_PRESCALE   4'h9

`endif

/* File: wdd_pkg.sv */
// Types shared by the watchdog time-base modules
`default_nettype none
package wdd_pkg;
  typedef enum logic [0:0] {
    PH_FIRST  = 1'b0,
    PH_SECOND = 1'b1
  } wdd_phase_type;
  typedef logic [2:0]  wdd_div_sel_type;
  typedef logic [3:0]  wdd_presc_sel_type;
  typedef logic [20:0] wdd_count_type;
endpackage
`default_nettype wire

/* File: wdd_tick_divider.sv */
// Odd divider of the slow oscillator ticks into watchdog count ticks
`default_nettype none
module wdd_tick_divider
  import wdd_pkg::*;
(
  // Clock and reset
  input  wire logic            core_clk,
  input  wire logic            rst,
  // Slow oscillator tick and selection
  input  wire logic            slowTick,
  input  wire wdd_div_sel_type divSel,
  // Divided tick
  output var  logic            countTick
);

  logic [3:0] divCnt_r;
  logic [3:0] divLast;
  // Checker helpers: slow ticks since the last count tick, clean while divSel held
  logic [3:0]      tickGap_r;
  logic            periodClean_r;
  wdd_div_sel_type divSelPrev_r;

  // Divide by 2*sel+1 gives 1,3,5..15
  assign divLast = {divSel, 1'b0};

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      divCnt_r  <= 4'h0;
      countTick <= 1'b0;
    end
    else if (slowTick)
    begin
      // Shrinking the divisor mid-count must not strand the counter
      if (divCnt_r >= divLast)
      begin
        divCnt_r  <= 4'h0;
        countTick <= 1'b1;
      end
      else
      begin
        divCnt_r  <= divCnt_r + 4'h1;
        countTick <= 1'b0;
      end
    end
    else
      countTick <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      tickGap_r <= 4'h0;
    else if (countTick)
      tickGap_r <= {3'h0, slowTick};
    else if (slowTick)
      tickGap_r <= tickGap_r + 4'h1;
  end

  // A divisor change mid-count leaves one period of unknown length
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      divSelPrev_r  <= 3'h0;
      periodClean_r <= 1'b1;
    end
    else
    begin
      divSelPrev_r <= divSel;
      if (countTick)
        periodClean_r <= 1'b1;
      else if (divSel != divSelPrev_r)
        periodClean_r <= 1'b0;
    end
  end

  divTickCause_a: assert property (@(posedge core_clk) disable iff (rst)
    countTick |-> $past(slowTick))
    else $error("count tick without slow tick");

  divByOne_a: assert property (@(posedge core_clk) disable iff (rst)
    (slowTick && divSel == 3'h0) |=> countTick)
    else $error("divide by one missed a tick");

  divByThree_a: assert property (@(posedge core_clk) disable iff (rst)
    (countTick && periodClean_r && $past(divSel) == 3'h1) |-> tickGap_r == 4'h3)
    else $error("divide by three tick period wrong");

endmodule // wdd_tick_divider
`default_nettype wire

/* File: wdd_watchdog_test.sv */
// Self-checking bench of the watchdog time base
`include "wdd_params.svh"
`default_nettype none
module wdd_watchdog_test
  import wdd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Clock, reset and bench state
  logic       core_clk = 1'b0;
  logic       rst = 1'b1;
  int         mismatches = 0;
  int         checks = 0;
  int         secSeen = 0;
  int         seed = 32'h7BC1F421;
  logic [7:0] v;
  // Design ports
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic       regWrStb = 1'b0;
  logic       regRdStb = 1'b0;
  logic [7:0] regRdData;
  logic       slowOscillatorClock = 1'b0;
  logic       wdRestart = 1'b0;
  logic       vectorAck = 1'b0;
  logic       earlyWarnIrq;
  logic       secondTimeout;
  logic       irq;

  wdd_watchdog DUT (.core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .slowOscillatorClock(slowOscillatorClock), .wdRestart(wdRestart), .vectorAck(vectorAck),
    .earlyWarnIrq(earlyWarnIrq), .secondTimeout(secondTimeout), .irq(irq));

  initial
  begin
    forever #5 core_clk = ~core_clk;
  end

  // A one-cycle pulse is easy to miss from the sequence, so count it here
  always @(posedge core_clk)
  begin
    if (secondTimeout === 1'b1)
      secSeen <= secSeen + 1;
  end

  function automatic int first_count(input int div, input int presc);
    return (2 * div + 1) * (2048 << presc);
  endfunction

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      mismatches++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr   <= a;
    regWrData <= d;
    regWrStb  <= 1'b1;
    @(posedge core_clk);
    regWrStb  <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    @(posedge core_clk);
    regAddr  <= a;
    regRdStb <= 1'b1;
    @(posedge core_clk);
    regRdStb <= 1'b0;
    #1;
    chk(name, exp, regRdData);
  endtask

  // Slow edges spaced 8 core cycles, enough for the synchroniser
  task automatic run(input int n);
    repeat (n)
    begin
      slowOscillatorClock <= 1'b1;
      repeat (4) @(posedge core_clk);
      slowOscillatorClock <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
    #1;
  endtask

  task automatic pulse_vec();
    @(posedge core_clk);
    vectorAck <= 1'b1;
    @(posedge core_clk);
    vectorAck <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  task automatic restart();
    @(posedge core_clk);
    wdRestart <= 1'b1;
    @(posedge core_clk);
    wdRestart <= 1'b0;
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    rd(`WDD_OFS_DIV_CTRL, 8'h00, "ctrl reset");
    rd(`WDD_OFS_PRESCALE, 8'h00, "prescale reset");
    rd(`WDD_OFS_IRQ_STATUS, 8'h00, "status reset");
    rd(`WDD_OFS_IRQ_MASK, 8'h00, "mask reset");
    rd(8'h10, 8'h00, "unmapped");
    // Slow clock idle, so random control values start no count
    repeat (8)
    begin
      v = 8'($random(seed));
      wr(`WDD_OFS_DIV_CTRL, v);
      rd(`WDD_OFS_DIV_CTRL, v & 8'h37, "ctrl bits");
      wr(`WDD_OFS_PRESCALE, {4'h0, v[3:0] % 4'hA});
      rd(`WDD_OFS_PRESCALE, {4'h0, v[3:0] % 4'hA}, "prescale");
      wr(`WDD_OFS_IRQ_MASK, v);
      rd(`WDD_OFS_IRQ_MASK, v & 8'h03, "mask");
    end
    // Reserved code held only while idle, never counted with
    wr(`WDD_OFS_PRESCALE, 8'h0C);
    rd(`WDD_OFS_PRESCALE, 8'h0C, "reserved code");
    wr(`WDD_OFS_PRESCALE, 8'h00);
    wr(`WDD_OFS_DIV_CTRL, 8'h04);
    wr(`WDD_OFS_IRQ_MASK, 8'h03);
    restart();
    run(first_count(0, 0) - 1);
    chk("warn early", 8'h00, {7'h0, earlyWarnIrq});
    run(1);
    chk("warn irq", 8'h01, {7'h0, earlyWarnIrq});
    chk("irq level", 8'h01, {7'h0, irq});
    rd(`WDD_OFS_DIV_CTRL, 8'h0C, "flag set");
    rd(`WDD_OFS_IRQ_STATUS, 8'h01, "status first");
    pulse_vec();
    rd(`WDD_OFS_DIV_CTRL, 8'h04, "flag vec clear");
    chk("warn off", 8'h00, {7'h0, earlyWarnIrq});
    wr(`WDD_OFS_IRQ_STATUS, 8'h01);
    rd(`WDD_OFS_IRQ_STATUS, 8'h00, "status w1c");
    chk("irq off", 8'h00, {7'h0, irq});
    run(first_count(0, 0) - 1);
    chk("second early", 8'h00, secSeen[7:0]);
    run(1);
    chk("second pulse", 8'h01, secSeen[7:0]);
    rd(`WDD_OFS_IRQ_STATUS, 8'h02, "status second");
    wr(`WDD_OFS_IRQ_MASK, 8'h01);
    #1;
    chk("irq masked", 8'h00, {7'h0, irq});
    wr(`WDD_OFS_IRQ_MASK, 8'h03);
    #1;
    chk("irq unmasked", 8'h01, {7'h0, irq});
    wr(`WDD_OFS_IRQ_STATUS, 8'h02);
    // Clear mode with divide by three
    wr(`WDD_OFS_DIV_CTRL, 8'h25);
    restart();
    run(first_count(1, 0) - 1);
    chk("div3 early", 8'h00, {7'h0, earlyWarnIrq});
    run(1);
    chk("div3 warn", 8'h01, {7'h0, earlyWarnIrq});
    pulse_vec();
    rd(`WDD_OFS_DIV_CTRL, 8'h2D, "flag kept");
    wr(`WDD_OFS_DIV_CTRL, 8'h2D);
    rd(`WDD_OFS_DIV_CTRL, 8'h25, "flag sw clear");
    end_sim();
  end
endmodule // wdd_watchdog_test
`default_nettype wire
